// ### common/thermistor_i2c_pkg.sv
/*
  Constants of the panel temperature readout slave: timing, codes, map.
  Assumes a 40 MHz system clock and a bus master that owns the serial clock.
*/
package thermistor_i2c_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned GLITCH_NS = 50;
  localparam int unsigned FILT_CYCLES = GLITCH_NS / CLK_PERIOD_NS + 1;
  localparam int unsigned REFRESH_S = 60;
  localparam logic [63:0] REFRESH_CYCLES = 64'(REFRESH_S) * 64'(CLK_HZ);
  // Framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Register map
  localparam logic [7:0] REG_TEMPERATURE_CODE = 8'h00;
  localparam logic [7:0] TEMP_CODE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Clamp limits of the temperature code
  localparam logic [7:0] TEMP_CODE_MIN = 8'hF6;
  localparam logic [7:0] TEMP_CODE_MAX = 8'h55;
  // Slave address, value arbitrary
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2A;
endpackage

// ### core/thermistor_i2c_readout.sv
/*
  Two-wire slave exposing one read-only panel temperature code register.
  Assumes the pins are resolved outside (pull-up on data) and that the
  converter result on adc_temp is synchronous to clk.
*/
`timescale 1ns/1ps
module thermistor_i2c_readout
  import thermistor_i2c_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR,
  parameter int unsigned ADC_W = 10,
  parameter logic [31:0] REFRESH_CYCLES_P = REFRESH_CYCLES[31:0]
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Converter result, signed degrees
  input wire logic signed [ADC_W-1:0] adc_temp
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_RNEXT
  } state_e;

  localparam logic signed [ADC_W-1:0] MIN_W = ADC_W'($signed(TEMP_CODE_MIN));
  localparam logic signed [ADC_W-1:0] MAX_W = ADC_W'($signed(TEMP_CODE_MAX));

  // Clamp converter result into the code range
  function automatic logic [7:0] clamp_code(input logic signed [ADC_W-1:0] t);
    if (t <= MIN_W) begin
      return TEMP_CODE_MIN;
    end
    if (t >= MAX_W) begin
      return TEMP_CODE_MAX;
    end
    return t[7:0];
  endfunction

  // Input synchronisers and glitch filters
  logic [1:0] sync1, sync2, filt, filt_d;
  logic [1:0] next_sync1, next_sync2, next_filt;
  logic [1:0] fcnt [2];
  logic [1:0] next_fcnt [2];
  logic scl_f, sda_f, scl_d, sda_d, sda_s;

  assign scl_f = filt[1];
  assign sda_f = filt[0];
  assign scl_d = filt_d[1];
  assign sda_d = filt_d[0];
  assign sda_s = sync2[0];

  // Next values of the filters: a level must hold for FILT_CYCLES samples
  always_comb begin
    next_sync1 = {scl_in, sda_in};
    next_sync2 = sync1;
    next_filt = filt;
    for (int i = 0; i < 2; i++) begin
      next_fcnt[i] = 2'h0;
      if (sync2[i] != filt[i]) begin
        if (fcnt[i] == 2'(FILT_CYCLES - 1)) begin
          next_filt[i] = sync2[i];
        end else begin
          next_fcnt[i] = fcnt[i] + 2'h1;
        end
      end
    end
  end

  // Registers of the filters, idle bus reads high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      filt <= 2'h3;
      filt_d <= 2'h3;
      fcnt[0] <= 2'h0;
      fcnt[1] <= 2'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      filt <= next_filt;
      filt_d <= filt;
      fcnt[0] <= next_fcnt[0];
      fcnt[1] <= next_fcnt[1];
    end
  end

  // Periodic refresh of the temperature code
  logic [31:0] refresh_cnt, next_refresh_cnt;
  logic [7:0] temperature_code, next_temperature_code;
  logic refresh_tick;

  assign refresh_tick = (refresh_cnt == 32'h0000_0000);

  // First load right after reset, then one every refresh period
  always_comb begin
    next_refresh_cnt = refresh_cnt - 32'h0000_0001;
    next_temperature_code = temperature_code;
    if (refresh_tick) begin
      next_refresh_cnt = REFRESH_CYCLES_P - 32'h0000_0001;
      next_temperature_code = clamp_code(adc_temp);
    end
  end

  // Refresh registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_cnt <= 32'h0000_0000;
      temperature_code <= TEMP_CODE_RESET;
    end else begin
      refresh_cnt <= next_refresh_cnt;
      temperature_code <= next_temperature_code;
    end
  end

  // Register read decode; the code comes in as an argument so that users see its changes
  function automatic logic [7:0] reg_read(input logic [7:0] sub, input logic [7:0] code);
    if (sub == REG_TEMPERATURE_CODE) begin
      return code;
    end
    return UNMAPPED_READ;
  endfunction

  // Bus protocol engine
  state_e state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, txreg, next_txreg;
  logic [7:0] sub_ptr, next_sub_ptr;
  logic sub_valid, next_sub_valid;
  logic rw, next_rw, next_oe_n;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] read_sel;

  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;
  assign start_cond = scl_f && scl_d && sda_d && !sda_f;
  assign stop_cond = scl_f && scl_d && !sda_d && sda_f;
  // Pointer from this transfer, else the temperature code
  assign read_sel = reg_read(sub_valid ? sub_ptr : REG_TEMPERATURE_CODE,
                             temperature_code);

  // Next state: sample on clock rise, change the line on clock fall
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_txreg = txreg;
    next_sub_ptr = sub_ptr;
    next_sub_valid = sub_valid;
    next_rw = rw;
    next_oe_n = sda_oe_n;
    if (start_cond) begin
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_oe_n = 1'b1;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
      next_oe_n = 1'b1;
      next_sub_valid = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_oe_n = 1'b1;
        end
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise && bitcnt < BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BYTE_BITS) begin
            if (state == ST_ADDR) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                next_oe_n = 1'b0;
                next_rw = shreg[0];
                next_state = ST_ADDR_ACK;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_SUB) begin
              next_sub_ptr = shreg;
              next_sub_valid = 1'b1;
              next_oe_n = 1'b0;
              next_state = ST_SUB_ACK;
            end else begin
              next_oe_n = 1'b0;
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (rw) begin
              next_oe_n = read_sel[7];
              next_txreg = {read_sel[6:0], 1'b0};
              next_bitcnt = 4'h1;
              next_state = ST_RDATA;
            end else begin
              next_oe_n = 1'b1;
              next_state = ST_SUB;
            end
          end
        end
        ST_SUB_ACK: begin
          if (scl_fall) begin
            next_oe_n = 1'b1;
            next_bitcnt = 4'h0;
            next_state = ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_oe_n = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == BYTE_BITS) begin
              next_oe_n = 1'b1;
              next_state = ST_RACK;
            end else begin
              next_oe_n = txreg[7];
              next_txreg = {txreg[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_state = sda_f ? ST_IDLE : ST_RNEXT;
          end
        end
        ST_RNEXT: begin
          if (scl_fall) begin
            next_oe_n = read_sel[7];
            next_txreg = {read_sel[6:0], 1'b0};
            next_bitcnt = 4'h1;
            next_state = ST_RDATA;
          end
        end
      endcase
    end
  end

  // Protocol registers; the line is only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      sub_ptr <= 8'h00;
      sub_valid <= 1'b0;
      rw <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      txreg <= next_txreg;
      sub_ptr <= next_sub_ptr;
      sub_valid <= next_sub_valid;
      rw <= next_rw;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

  // Checks on the driven line, the decoder and the refresh
  line_low_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    sda_out == 1'b0)
    else $error("data pin driven high");

  line_change_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sda_oe_n) |-> !scl_f || $past(start_cond) || $past(stop_cond))
    else $error("data line changed while clock high");

  start_detect_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_cond |=> state == ST_ADDR && bitcnt == 4'h0)
    else $error("start not taken");

  stop_detect_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_cond |=> state == ST_IDLE && sda_oe_n)
    else $error("stop did not end transfer");

  addr_mismatch_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_ADDR && scl_fall && !start_cond && !stop_cond &&
    bitcnt == BYTE_BITS && shreg[7:1] != SLAVE_ADDR |=> state == ST_IDLE ##1 sda_oe_n)
    else $error("foreign address not ignored");

  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_ADDR && scl_fall && !start_cond && !stop_cond &&
    bitcnt == BYTE_BITS && shreg[7:1] == SLAVE_ADDR |=> !sda_oe_n && state == ST_ADDR_ACK)
    else $error("own address not acknowledged");

  read_msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_ADDR_ACK && scl_fall && rw && !start_cond && !stop_cond
    |=> sda_oe_n == $past(read_sel[7]) && txreg == {$past(read_sel[6:0]), 1'b0})
    else $error("read byte not started with msb");

  glitch_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sda_f) |-> $past(sda_s, 1) == sda_f && $past(sda_s, 2) == sda_f &&
    $past(sda_s, 3) == sda_f)
    else $error("short pulse passed the filter");

  code_clamped_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(refresh_tick) && $past(rst_n) |-> temperature_code == clamp_code($past(adc_temp)) &&
    $signed(temperature_code) >= $signed(TEMP_CODE_MIN) &&
    $signed(temperature_code) <= $signed(TEMP_CODE_MAX))
    else $error("temperature code out of range");

  refresh_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(temperature_code) |-> $past(refresh_tick))
    else $error("temperature code changed between refreshes");

endmodule

// ### verif/i2c_master_model.sv
/*
  Behavioural two-wire bus master that owns the serial clock.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF_NS = 240
) (
  // Resolved data wire
  input wire logic sda_wire,
  // Driven pins, clock stands high between frames
  output logic scl,
  output logic sda_low,
  // Byte and ack bit seen on the wire, with a change marker
  output logic [8:0] got,
  output logic got_tgl
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 9'h000;
    got_tgl = 1'b0;
  end

  // Start or repeated start, leaves the clock low
  task automatic start();
    #(HALF_NS / 2);
    sda_low = 1'b0;
    #(HALF_NS / 2);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
  endtask

  // Stop, leaves the bus idle
  task automatic stop();
    #(HALF_NS / 2);
    sda_low = 1'b1;
    #(HALF_NS / 2);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b0;
    #(HALF_NS);
  endtask

  // One clock period; data changes only while the clock is low
  task automatic bit_io(input logic b, input bit glitch, output logic r);
    #(HALF_NS / 2);
    sda_low = !b;
    #(HALF_NS / 2);
    scl = 1'b1;
    #(HALF_NS / 2);
    if (glitch) begin
      scl = 1'b0;
      #50;
      scl = 1'b1;
    end
    #(HALF_NS / 4);
    r = sda_wire;
    #(HALF_NS / 4);
    scl = 1'b0;
  endtask

  // Eight bits MSB first plus the ack bit; reports what the wire showed
  task automatic xfer(input logic [7:0] d, input logic mack, input int gl);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], gl == i, r[i + 1]);
    end
    bit_io(mack, 1'b0, r[0]);
    got = r;
    got_tgl = !got_tgl;
  endtask
endmodule

// ### verif/test_thermistor_i2c_readout.sv
/*
  Self-checking bench of the panel temperature readout slave.
  Assumes the master model owns the link clock; data wire has a pull-up.
*/
`timescale 1ns/1ps
module test_thermistor_i2c_readout
  import thermistor_i2c_pkg::*;
;
  localparam logic [6:0] SA = DEFAULT_SLAVE_ADDR;
  logic clk;
  logic rst_n;
  logic signed [9:0] adc_temp;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe_n;
  logic sda_w;
  logic [8:0] got;
  logic got_tgl;
  logic [8:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int temps[8] = '{-512, -11, -10, -1, 0, 25, 85, 511};

  // Open-drain wire with pull-up
  assign sda_w = !(sda_low || (!sda_oe_n && !sda_out));

  thermistor_i2c_readout #(.SLAVE_ADDR(SA), .ADC_W(10), .REFRESH_CYCLES_P(32'h0000_0064)) u_dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .adc_temp(adc_temp));

  i2c_master_model #(.HALF_NS(240)) u_master (
    .sda_wire(sda_w), .scl(scl), .sda_low(sda_low), .got(got), .got_tgl(got_tgl));

  // System clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected register code for a converter reading
  function automatic logic [7:0] clamp(input int t);
    if (t <= -10) return TEMP_CODE_MIN;
    if (t >= 85) return TEMP_CODE_MAX;
    return 8'(t);
  endfunction

  // Note the expected byte and ack bit, then move the byte
  task automatic byte_io(input logic [7:0] d, input logic mack, input logic [7:0] eb,
                         input logic ea, input int gl);
    exp_q.push_back({eb, ea});
    u_master.xfer(d, mack, gl);
  endtask

  // Two-byte read, optionally preceded by a subaddress write
  task automatic read_reg(input bit comb, input logic [7:0] sub, input logic [7:0] ev,
                          input int gl);
    // Keep link edges off the system clock edges so a 50 ns pulse spans two samples
    @(posedge clk);
    #2;
    u_master.start();
    if (comb) begin
      byte_io({SA, 1'b0}, 1'b1, {SA, 1'b0}, 1'b0, -1);
      byte_io(sub, 1'b1, sub, 1'b0, -1);
      u_master.start();
    end
    byte_io({SA, 1'b1}, 1'b1, {SA, 1'b1}, 1'b0, gl);
    byte_io(8'hff, 1'b0, ev, 1'b0, -1);
    byte_io(8'hff, 1'b1, ev, 1'b1, -1);
    u_master.stop();
  endtask

  // New converter value, then wait past one refresh period
  task automatic set_temp(input int t);
    @(posedge clk);
    #2;
    adc_temp = 10'(t);
    repeat (110) @(posedge clk);
  endtask

  // Compare each reported byte with the oldest expectation
  initial begin
    logic [8:0] e;
    wait (rst_n === 1'b1);
    forever begin
      @(got_tgl);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'hxxx;
      comparisons++;
      if (got !== e) begin
        error_cnt++;
        $display("wrong value at %0t ns: got %h, expected %h", $time, got, e);
      end
    end
  end

  // Watchdog against a hung bus
  initial begin
    #2_000_000;
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    int t;
    rst_n = 1'b0;
    adc_temp = '0;
    t = $urandom(32'h0000_082e);
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (20) @(posedge clk);
    // Short reads across clamp limits and random codes, one with a clock glitch
    for (int i = 0; i < 11; i++) begin
      t = (i < 8) ? temps[i] : int'($urandom_range(95)) - 10;
      set_temp(t);
      read_reg(1'b0, 8'h00, clamp(t), (i == 3) ? 3 : -1);
    end
    // Reset in mid-run; the code must be reloaded right after release
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (20) @(posedge clk);
    // Combined reads of the mapped and an unmapped subaddress, then a short read
    read_reg(1'b1, REG_TEMPERATURE_CODE, clamp(t), -1);
    read_reg(1'b1, 8'h05, UNMAPPED_READ, -1);
    read_reg(1'b0, 8'h00, clamp(t), -1);
    // Foreign address gets no ack
    @(posedge clk);
    #2;
    u_master.start();
    byte_io({SA ^ 7'h01, 1'b1}, 1'b1, {SA ^ 7'h01, 1'b1}, 1'b1, -1);
    u_master.stop();
    // One data byte acked, the next ignored, register unchanged
    @(posedge clk);
    #2;
    u_master.start();
    byte_io({SA, 1'b0}, 1'b1, {SA, 1'b0}, 1'b0, -1);
    byte_io(REG_TEMPERATURE_CODE, 1'b1, REG_TEMPERATURE_CODE, 1'b0, -1);
    byte_io(8'h5a, 1'b1, 8'h5a, 1'b0, -1);
    byte_io(8'ha5, 1'b1, 8'ha5, 1'b1, -1);
    u_master.stop();
    read_reg(1'b0, 8'h00, clamp(t), -1);
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule
